// file: verilog/contactless_irq_error_status.sv
// Behaviour
// - Bit 7 selects set or clear of flags.
// - Secure input edge sets bit 4.
// - Detected mode sets bit 3 once.
// - Checksum command completion sets bit 2.
// - Field on sets bit 1, off bit 0.
// - Host FIFO write in busy window errs.
// - Overheat sets error, switches antenna off.
// - Late counterpart field errs in active framing.
// - Write into full FIFO sets overflow.
// - Collision flag; reads one above 106.
// - Checksum check failure sets error bit 2.
// - Parity failure at 106 sets error.
// - Bad start or length sets framing error.
// - Three command faults set framing error.
// - Command start clears errors except overheat.
// - Checksum good and finished status bits.
// - Interrupt bit ORs enabled pending requests.
// - Countdown active follows timer or enable.
// - Watermark bits compare against threshold.
// - Target selected set in anticollision, field clears.
// - Cipher set by authentication, software clears.
// - Three-bit phase encodes transceiver state.
// - Write-only bits read back as zero.
`timescale 1ns/1ns
module contactless_irq_error_status
    import flag_bank_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_BYTES
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Host register interface
    input  wire logic [5:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Pins and analog levels
    input  wire logic       secure_input_signal,
    input  wire logic       field_present,
    input  wire logic       overheat_sense,
    input  wire logic       freq_in_range,
    // Command state
    input  wire logic       cmd_start,
    input  wire logic       auto_anticollision_cmd,
    input  wire logic       authentication_cmd,
    input  wire logic       checksum_compute_cmd,
    input  wire logic       transceive_cmd,
    input  wire logic       cmd_idle,
    input  wire logic       initiator,
    input  wire logic       passive_mode,
    input  wire logic       active_mode,
    input  wire logic [1:0] rate_sel,
    input  wire logic       type_a_or_p2p,
    // Mode detector and checksum coprocessor
    input  wire logic       rf_reset,
    input  wire logic       mode_detected,
    input  wire logic       checksum_all_processed,
    input  wire logic       checksum_calc_busy,
    input  wire logic       checksum_result_zero,
    // Receiver and framing events
    input  wire logic [1:0] receive_framing_sel,
    input  wire logic [1:0] transmit_framing_sel,
    input  wire logic       counterpart_field_late,
    input  wire logic       bit_collision,
    input  wire logic       rx_checksum_check_on,
    input  wire logic       checksum_mismatch,
    input  wire logic       parity_fail,
    input  wire logic       sof_bad,
    input  wire logic       sync_byte_detect_on,
    input  wire logic       byte_length_violation,
    input  wire logic       auth_byte_count_bad,
    input  wire logic       miller_short_pulses,
    input  wire logic       target_answered,
    input  wire logic       auth_success,
    // FIFO
    input  wire logic       host_fifo_write,
    input  wire logic       internal_fifo_write,
    input  wire logic [6:0] fifo_byte_count,
    input  wire logic [5:0] fifo_threshold,
    // Timer and interrupt enables
    input  wire logic       timer_running,
    input  wire logic       gated_mode,
    input  wire logic       timer_reg_enable,
    input  wire logic [4:0] req_enable,
    input  wire logic       primary_req_pending,
    // Modem sequencing
    input  wire logic       tx_begin,
    input  wire logic       rx_begin,
    input  wire logic       start_send,
    input  wire logic       tx_wait_rf,
    input  wire logic       rx_wait_rf,
    input  wire logic       tx_min_wait_done,
    input  wire logic       rx_min_wait_done,
    input  wire logic       tx_done,
    input  wire logic       rx_data_start,
    input  wire logic       rx_done,
    // Outputs to the rest of the core
    output logic            antenna_off,
    output logic            irq_active,
    output logic            any_error,
    output logic      [4:0] req_flags,
    output logic      [2:0] txrx_phase,
    output logic            force_high_speed
);

    typedef struct packed {
        logic [4:0]  req;
        logic [7:0]  err;
        logic        det_on;
        logic        crc_good;
        logic        crc_fin;
        logic        tgt;
        logic        cipher;
        logic        temp_clr;
        logic        hs;
        logic        irq;
        logic        run;
        logic        hi;
        logic        lo;
        logic        err_any;
        logic        antenna_off;
        txrx_phase_t phase;
        logic [7:0]  rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [3:0] pin_level;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    edge_sync #(
        .WIDTH (4)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({freq_in_range, overheat_sense,
                    field_present, secure_input_signal}),
        .level    (pin_level),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    logic       sec_edge;
    logic       field_on;
    logic       field_up;
    logic       field_down;
    logic       hot;
    logic       freq_ok;
    logic       at_106;
    logic       in_flight;
    logic       rx_startup;
    logic       wr_req;
    logic       wr_stat2;
    logic [7:0] free_bytes;
    logic [7:0] err_view;
    logic [7:0] stat1_view;
    logic [7:0] stat2_view;

    assign sec_edge   = pin_rise[0] | pin_fall[0];
    assign field_on   = pin_level[1];
    assign field_up   = pin_rise[1];
    assign field_down = pin_fall[1];
    assign hot        = pin_level[2];
    assign freq_ok    = pin_level[3];
    assign at_106     = (rate_sel == RATE_106);
    assign wr_req     = reg_wr && (reg_addr == SECONDARY_IRQ_REQUEST_OFS);
    assign wr_stat2   = reg_wr && (reg_addr == SECONDARY_STATUS_OFS);
    assign in_flight  = (s_q.phase == PH_RX_WAIT) ||
                        (s_q.phase == PH_WAIT_DATA) ||
                        (s_q.phase == PH_RECEIVING);
    assign rx_startup = (s_q.phase == PH_SENDING && tx_done) ||
                        (s_q.phase == PH_IDLE && rx_begin);
    assign free_bytes = 8'(FIFO_DEPTH) - {1'b0, fifo_byte_count};

    always_comb begin
        err_view = s_q.err;
        if (!at_106) begin
            err_view[BIT_COLLISION_ERR_BIT] = 1'b1;
        end
        stat1_view = {freq_ok, s_q.crc_good, s_q.crc_fin, s_q.irq,
                      s_q.run, field_on, s_q.hi, s_q.lo};
        stat2_view = {s_q.temp_clr, s_q.hs, 1'b0, s_q.tgt, s_q.cipher,
                      s_q.phase};
    end

    always_comb begin
        s_d = s_q;

        if (wr_req) begin
            if (reg_wdata[FLAG_WRITE_POLARITY_BIT]) begin
                s_d.req = s_q.req | reg_wdata[4:0];
            end else begin
                s_d.req = s_q.req & ~reg_wdata[4:0];
            end
        end
        // hardware sets are sticky and win
        if (sec_edge) begin
            s_d.req[SECURE_INPUT_EDGE_REQ_BIT] = 1'b1;
        end
        if ((cmd_start && auto_anticollision_cmd) || rf_reset) begin
            s_d.det_on = 1'b1;
        end
        if (s_q.det_on && mode_detected) begin
            s_d.det_on = 1'b0;
            s_d.req[MODE_FOUND_REQ_BIT] = 1'b1;
        end
        if (checksum_compute_cmd && checksum_all_processed) begin
            s_d.req[CHECKSUM_DONE_REQ_BIT] = 1'b1;
        end
        if (field_up) begin
            s_d.req[FIELD_APPEARED_REQ_BIT] = 1'b1;
        end
        if (field_down) begin
            s_d.req[FIELD_VANISHED_REQ_BIT] = 1'b1;
        end

        if (cmd_start) begin
            s_d.err = s_q.err & (8'h01 << OVERHEAT_ERR_BIT);
        end
        if (rx_startup) begin
            s_d.err[BIT_COLLISION_ERR_BIT] = 1'b0;
            s_d.err[CHECKSUM_FAIL_ERR_BIT] = 1'b0;
            s_d.err[ODD_EVEN_CHECK_ERR_BIT] = 1'b0;
            s_d.err[FRAMING_RULE_ERR_BIT] = 1'b0;
        end
        if (wr_stat2 && reg_wdata[TEMP_SENSE_CLEAR_BIT] && !hot) begin
            s_d.err[OVERHEAT_ERR_BIT] = 1'b0;
        end
        if (hot) begin
            s_d.err[OVERHEAT_ERR_BIT] = 1'b1;
        end
        if (host_fifo_write &&
            (auto_anticollision_cmd || authentication_cmd || in_flight)) begin
            s_d.err[ILLEGAL_FIFO_WRITE_ERR_BIT] = 1'b1;
        end
        if (active_mode && counterpart_field_late &&
            (receive_framing_sel == FRAMING_ACTIVE ||
             transmit_framing_sel == FRAMING_ACTIVE)) begin
            s_d.err[FIELD_TIMEOUT_ERR_BIT] = 1'b1;
        end
        if ((host_fifo_write || internal_fifo_write) &&
            fifo_byte_count >= 7'(FIFO_DEPTH)) begin
            s_d.err[FIFO_OVERFLOW_ERR_BIT] = 1'b1;
        end
        if (bit_collision) begin
            s_d.err[BIT_COLLISION_ERR_BIT] = 1'b1;
        end
        if (rx_checksum_check_on && checksum_mismatch) begin
            s_d.err[CHECKSUM_FAIL_ERR_BIT] = 1'b1;
        end
        if (parity_fail && at_106 && type_a_or_p2p) begin
            s_d.err[ODD_EVEN_CHECK_ERR_BIT] = 1'b1;
        end
        if ((sof_bad && at_106) ||
            (byte_length_violation && sync_byte_detect_on && !at_106)) begin
            s_d.err[FRAMING_RULE_ERR_BIT] = 1'b1;
        end
        if ((auto_anticollision_cmd && initiator) ||
            (authentication_cmd && auth_byte_count_bad) ||
            miller_short_pulses) begin
            s_d.err[FRAMING_RULE_ERR_BIT] = 1'b1;
        end
        s_d.err_any = |s_d.err;
        s_d.antenna_off = s_d.err[OVERHEAT_ERR_BIT];

        s_d.crc_good = checksum_result_zero && !checksum_calc_busy;
        if (cmd_start) begin
            s_d.crc_fin = 1'b0;
        end
        if (checksum_compute_cmd && checksum_all_processed) begin
            s_d.crc_fin = 1'b1;
        end
        s_d.irq = primary_req_pending || |(s_d.req & req_enable);
        s_d.run = gated_mode ? timer_reg_enable : timer_running;
        s_d.hi = free_bytes <= {2'b00, fifo_threshold};
        s_d.lo = fifo_byte_count <= {1'b0, fifo_threshold};

        // Secondary status: software may only clear the dynamic bits.
        if (wr_stat2) begin
            s_d.temp_clr = reg_wdata[TEMP_SENSE_CLEAR_BIT];
            s_d.hs = reg_wdata[FORCE_HIGH_SPEED_BIT];
            if (!reg_wdata[TARGET_SELECTED_BIT]) begin
                s_d.tgt = 1'b0;
            end
            if (!reg_wdata[CIPHER_ACTIVE_BIT]) begin
                s_d.cipher = 1'b0;
            end
        end
        if (auto_anticollision_cmd && passive_mode && target_answered) begin
            s_d.tgt = 1'b1;
        end
        if (field_down) begin
            s_d.tgt = 1'b0;
        end
        if (authentication_cmd && auth_success) begin
            s_d.cipher = 1'b1;
        end

        case (s_q.phase)
            PH_IDLE: begin
                if (transceive_cmd) begin
                    s_d.phase = PH_WAIT_START;
                end else if (tx_begin) begin
                    s_d.phase = PH_TX_WAIT;
                end else if (rx_begin) begin
                    s_d.phase = PH_RX_WAIT;
                end
            end
            PH_WAIT_START: begin
                if (start_send) begin
                    s_d.phase = PH_TX_WAIT;
                end
            end
            PH_TX_WAIT: begin
                if (tx_min_wait_done && (!tx_wait_rf || field_on)) begin
                    s_d.phase = PH_SENDING;
                end
            end
            PH_SENDING: begin
                if (tx_done) begin
                    s_d.phase = PH_RX_WAIT;
                end
            end
            PH_RX_WAIT: begin
                if (rx_min_wait_done && (!rx_wait_rf || field_on)) begin
                    s_d.phase = PH_WAIT_DATA;
                end
            end
            PH_WAIT_DATA: begin
                if (rx_data_start) begin
                    s_d.phase = PH_RECEIVING;
                end
            end
            PH_RECEIVING: begin
                if (rx_done) begin
                    s_d.phase = transceive_cmd ? PH_WAIT_START : PH_IDLE;
                end
            end
            default: begin
                s_d.phase = PH_IDLE;
            end
        endcase
        // Stopping the command always returns the modem to idle.
        if (cmd_idle) begin
            s_d.phase = PH_IDLE;
        end

        if (reg_rd) begin
            case (reg_addr)
                SECONDARY_IRQ_REQUEST_OFS: s_d.rdata = {3'b000, s_q.req};
                LAST_COMMAND_ERRORS_OFS:   s_d.rdata = err_view;
                PRIMARY_STATUS_OFS:        s_d.rdata = stat1_view;
                SECONDARY_STATUS_OFS:      s_d.rdata = stat2_view;
                default:                   s_d.rdata = DATA_RESET;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{req: REQ_RESET, err: ERR_RESET, phase: PH_IDLE,
                     rdata: DATA_RESET, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata        = s_q.rdata;
    assign antenna_off      = s_q.antenna_off;
    assign irq_active       = s_q.irq;
    assign any_error        = s_q.err_any;
    assign req_flags        = s_q.req;
    assign txrx_phase       = s_q.phase;
    assign force_high_speed = s_q.hs;

endmodule

// file: verilog/flag_bank_pkg.sv
package flag_bank_pkg;

    // Register offsets on the host register interface.
    localparam logic [5:0] SECONDARY_IRQ_REQUEST_OFS = 6'h05;
    localparam logic [5:0] LAST_COMMAND_ERRORS_OFS   = 6'h06;
    localparam logic [5:0] PRIMARY_STATUS_OFS        = 6'h07;
    localparam logic [5:0] SECONDARY_STATUS_OFS      = 6'h08;

    // Secondary interrupt-request register fields.
    localparam int FLAG_WRITE_POLARITY_BIT   = 7;
    localparam int SECURE_INPUT_EDGE_REQ_BIT = 4;
    localparam int MODE_FOUND_REQ_BIT        = 3;
    localparam int CHECKSUM_DONE_REQ_BIT     = 2;
    localparam int FIELD_APPEARED_REQ_BIT    = 1;
    localparam int FIELD_VANISHED_REQ_BIT    = 0;
    localparam int REQ_WIDTH                 = 5;

    // Error register fields.
    localparam int ILLEGAL_FIFO_WRITE_ERR_BIT = 7;
    localparam int OVERHEAT_ERR_BIT           = 6;
    localparam int FIELD_TIMEOUT_ERR_BIT      = 5;
    localparam int FIFO_OVERFLOW_ERR_BIT      = 4;
    localparam int BIT_COLLISION_ERR_BIT      = 3;
    localparam int CHECKSUM_FAIL_ERR_BIT      = 2;
    localparam int ODD_EVEN_CHECK_ERR_BIT     = 1;
    localparam int FRAMING_RULE_ERR_BIT       = 0;

    // Primary status fields.
    localparam int FREQ_OK_BIT           = 7;
    localparam int CHECKSUM_GOOD_BIT     = 6;
    localparam int CHECKSUM_FINISHED_BIT = 5;
    localparam int IRQ_STATUS_BIT        = 4;
    localparam int COUNTDOWN_ACTIVE_BIT  = 3;
    localparam int FIELD_PRESENT_BIT     = 2;
    localparam int FIFO_NEARLY_FULL_BIT  = 1;
    localparam int FIFO_NEARLY_EMPTY_BIT = 0;

    // Secondary status fields.
    localparam int TEMP_SENSE_CLEAR_BIT = 7;
    localparam int FORCE_HIGH_SPEED_BIT = 6;
    localparam int TARGET_SELECTED_BIT  = 4;
    localparam int CIPHER_ACTIVE_BIT    = 3;

    // Values after reset.
    localparam logic [4:0] REQ_RESET  = 5'h00;
    localparam logic [7:0] ERR_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // Framing selector value that enables the field timeout check.
    localparam logic [1:0] FRAMING_ACTIVE = 2'h1;

    // Bit rate selector codes.
    localparam logic [1:0] RATE_106 = 2'h0;
    localparam logic [1:0] RATE_212 = 2'h1;
    localparam logic [1:0] RATE_424 = 2'h2;

    // FIFO size in bytes.
    localparam int FIFO_BYTES = 64;

    // Declared order gives the codes 000 to 110.
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_WAIT_START,
        PH_TX_WAIT,
        PH_SENDING,
        PH_RX_WAIT,
        PH_WAIT_DATA,
        PH_RECEIVING
    } txrx_phase_t;

endpackage

// file: verilog/edge_sync.sv
`timescale 1ns/1ns
module edge_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Asynchronous levels
    input  wire logic [WIDTH-1:0] async_in,
    // Synchronised level and edges
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Edges look only at the second and third stage, never the first.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign level[i] = s_q.sync[i];
            assign rise[i]  = s_q.sync[i] & ~s_q.prev[i];
            assign fall[i]  = ~s_q.sync[i] & s_q.prev[i];
        end
    endgenerate

endmodule

// file: dv/flag_bank_checker.sv
`timescale 1ns/1ns
module flag_bank_checker #(
    parameter int FIFO_DEPTH = 64
) (
    // Clock, reset and host bus
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    // Event and command inputs
    input wire logic       overheat_sense,
    input wire logic       cmd_idle,
    input wire logic       authentication_cmd,
    input wire logic       checksum_compute_cmd,
    input wire logic       transceive_cmd,
    input wire logic       checksum_all_processed,
    input wire logic       host_fifo_write,
    input wire logic       internal_fifo_write,
    input wire logic [6:0] fifo_byte_count,
    input wire logic [4:0] req_enable,
    input wire logic       tx_begin,
    input wire logic       rx_begin,
    // Design outputs
    input wire logic       antenna_off,
    input wire logic       irq_active,
    input wire logic       any_error,
    input wire logic [4:0] req_flags,
    input wire logic [2:0] txrx_phase
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic wr_req;
    assign wr_req = reg_wr && reg_addr == 6'h05;

    a_req_set_bit: assert property (
        wr_req && reg_wdata[7] && reg_wdata[0] |=> req_flags[0])
        else $error("request flag not set by write");
    a_req_clear_bit: assert property (
        wr_req && !reg_wdata[7] && reg_wdata[2] && !checksum_all_processed
        |=> !req_flags[2]) else $error("request flag not cleared");
    a_req_flag_sticky: assert property (
        !(wr_req && !reg_wdata[7])
        |=> (req_flags & $past(req_flags)) == $past(req_flags))
        else $error("request flag dropped by itself");
    a_crc_done_set: assert property (
        checksum_compute_cmd && checksum_all_processed |=> req_flags[2])
        else $error("checksum done flag missing");
    a_heat_antenna_off: assert property (
        overheat_sense [*4] |=> antenna_off)
        else $error("antenna not switched off");
    a_overflow_err: assert property (
        internal_fifo_write && fifo_byte_count >= 7'(FIFO_DEPTH)
        |=> ##[0:1] any_error) else $error("overflow not flagged");
    a_illegal_write: assert property (
        host_fifo_write && authentication_cmd |=> ##[0:1] any_error)
        else $error("illegal write not flagged");
    a_irq_enabled: assert property (
        |(req_flags & $past(req_enable)) |-> irq_active)
        else $error("interrupt status missing");
    a_phase_start: assert property (
        txrx_phase == 3'h0 && transceive_cmd && !cmd_idle && !tx_begin
        && !rx_begin |=> txrx_phase == 3'h1)
        else $error("phase did not leave idle");
    a_phase_idle: assert property (
        cmd_idle |=> txrx_phase == 3'h0) else $error("phase not idle");

    c_flag_set: cover property (wr_req && reg_wdata[7]);
    c_receiving: cover property (txrx_phase == 3'h6);
    c_antenna: cover property ($rose(antenna_off));
endmodule

bind contactless_irq_error_status flag_bank_checker #(
    .FIFO_DEPTH(FIFO_DEPTH)
) u_chk (.*);

// file: dv/host_model.sv
`timescale 1ns/1ns
module host_model (
    // Clock
    input  wire logic       ref_clk,
    // Register bus
    output logic      [5:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 6'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        // Stale data is inverted so a late sample cannot pass by luck.
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import flag_bank_pkg::*;
    logic       ref_clk, rst_n, reg_wr, reg_rd;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic       antenna_off, irq_active, any_error, force_high_speed;
    logic [4:0] req_flags;
    logic [2:0] txrx_phase;
    bit secure_input_signal, field_present, overheat_sense, freq_in_range;
    bit cmd_start, auto_anticollision_cmd, authentication_cmd, cmd_idle;
    bit checksum_compute_cmd, transceive_cmd, initiator, passive_mode;
    bit active_mode, type_a_or_p2p, rf_reset, mode_detected, parity_fail;
    bit checksum_all_processed, checksum_calc_busy, checksum_result_zero;
    bit counterpart_field_late, bit_collision, rx_checksum_check_on;
    bit checksum_mismatch, sof_bad, sync_byte_detect_on, auth_success;
    bit byte_length_violation, auth_byte_count_bad, miller_short_pulses;
    bit target_answered, host_fifo_write, internal_fifo_write, rx_done;
    bit timer_running, gated_mode, timer_reg_enable, primary_req_pending;
    bit tx_begin, rx_begin, start_send, tx_wait_rf, rx_wait_rf, tx_done;
    bit tx_min_wait_done, rx_min_wait_done, rx_data_start;
    bit [1:0]   rate_sel, receive_framing_sel, transmit_framing_sel;
    bit [6:0]   fifo_byte_count;
    bit [5:0]   fifo_threshold;
    bit [4:0]   req_enable;
    int         mismatches, samples_checked, cyc;
    bit [6:0]   wm_cnt[4] = '{7'h3C, 7'h3B, 7'h04, 7'h05};
    logic [7:0] wm_exp[4] = '{8'h02, 8'h00, 8'h01, 8'h00};

    contactless_irq_error_status #(.FIFO_DEPTH(64)) u_dut (.*);
    host_model u_host (.*);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(logic [5:0] a, logic [7:0] m, logic [7:0] e, string n);
        u_host.rd(a, v);
        chk(n, v & m, e);
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic pulse(ref bit s);
        @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask
    task automatic step(ref bit s, input logic [2:0] p);
        pulse(s);
        rc(6'h08, 8'hFF, {5'h00, p}, "phase");
    endtask
    task automatic end_of_test;
        $display("mismatches %0d samples_checked %0d", mismatches,
                 samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            end_of_test;
        end
    end

    initial begin
        rst_n = 1'b0;
        tick(5);
        rst_n = 1'b1;
        rc(6'h05, 8'hFF, 8'h00, "req reset");
        rc(6'h06, 8'hFF, ERR_RESET, "err reset");
        rc(6'h20, 8'hFF, 8'h00, "unmapped");
        u_host.wr(6'h05, 8'h9F);
        rc(6'h05, 8'hFF, 8'h1F, "req set");
        u_host.wr(6'h05, 8'h05);
        rc(6'h05, 8'hFF, 8'h1A, "req clear");
        u_host.wr(6'h05, 8'h1A);
        rc(6'h05, 8'hFF, 8'h00, "req none");
        field_present = 1'b1;
        tick(6);
        rc(6'h07, 8'h04, 8'h04, "field on");
        rc(6'h05, 8'hFF, 8'h02, "field req");
        field_present = 1'b0;
        secure_input_signal = 1'b1;
        tick(6);
        rc(6'h05, 8'hFF, 8'h13, "edge req");
        checksum_compute_cmd = 1'b1;
        checksum_result_zero = 1'b1;
        pulse(checksum_all_processed);
        req_enable = 5'h04;
        tick(3);
        rc(6'h05, 8'hFF, 8'h17, "crc req");
        rc(6'h07, 8'h70, 8'h70, "crc good irq");
        u_host.wr(6'h05, 8'h17);
        req_enable = 5'h00;
        checksum_compute_cmd = 1'b0;
        rc(6'h05, 8'hFF, 8'h00, "req cleared");
        fifo_byte_count = 7'h40;
        pulse(internal_fifo_write);
        authentication_cmd = 1'b1;
        pulse(host_fifo_write);
        authentication_cmd = 1'b0;
        overheat_sense = 1'b1;
        tick(6);
        rc(6'h06, 8'hFF, 8'hD0, "errors");
        pulse(cmd_start);
        u_host.wr(6'h06, 8'hFF);
        rc(6'h06, 8'hFF, 8'h40, "cmd clears");
        overheat_sense = 1'b0;
        tick(4);
        u_host.wr(6'h08, 8'hC0);
        chk("hs pin", {7'h00, force_high_speed}, 8'h01);
        rc(6'h06, 8'hFF, 8'h00, "temp clear");
        rate_sel = RATE_212;
        rc(6'h06, 8'h08, 8'h08, "coll 212");
        rate_sel = RATE_106;
        active_mode = 1'b1;
        receive_framing_sel = FRAMING_ACTIVE;
        rx_checksum_check_on = 1'b1;
        type_a_or_p2p = 1'b1;
        {counterpart_field_late, bit_collision, checksum_mismatch,
         parity_fail, sof_bad} = 5'h1F;
        tick(1);
        {counterpart_field_late, bit_collision, checksum_mismatch,
         parity_fail, sof_bad} = 5'h00;
        rc(6'h06, 8'h20, 8'h20, "field late");
        rc(6'h06, 8'h08, 8'h08, "collision");
        rc(6'h06, 8'h04, 8'h04, "crc fail");
        rc(6'h06, 8'h02, 8'h02, "parity");
        rc(6'h06, 8'h01, 8'h01, "bad sof");
        pulse(rx_begin);
        rc(6'h06, 8'hFF, 8'h20, "rx startup");
        pulse(cmd_idle);
        pulse(miller_short_pulses);
        rc(6'h06, 8'h01, 8'h01, "miller");
        auto_anticollision_cmd = 1'b1;
        passive_mode = 1'b1;
        pulse(cmd_start);
        pulse(mode_detected);
        pulse(target_answered);
        auto_anticollision_cmd = 1'b0;
        rc(6'h05, 8'h08, 8'h08, "mode req");
        rc(6'h08, 8'h10, 8'h10, "target");
        rc(6'h06, 8'hFF, 8'h00, "cmd clears 2");
        authentication_cmd = 1'b1;
        pulse(auth_success);
        authentication_cmd = 1'b0;
        rc(6'h08, 8'hFF, 8'hD8, "cipher on");
        u_host.wr(6'h08, 8'h00);
        rc(6'h08, 8'hFF, 8'h00, "cipher off");
        gated_mode = 1'b1;
        timer_reg_enable = 1'b1;
        rc(6'h07, 8'h08, 8'h08, "countdown");
        fifo_threshold = 6'h04;
        foreach (wm_cnt[i]) begin
            fifo_byte_count = wm_cnt[i];
            rc(6'h07, 8'h03, wm_exp[i], "watermark");
        end
        transceive_cmd = 1'b1;
        tick(2);
        rc(6'h08, 8'hFF, 8'h01, "phase start");
        step(start_send, 3'h2);
        step(tx_min_wait_done, 3'h3);
        step(tx_done, 3'h4);
        step(rx_min_wait_done, 3'h5);
        step(rx_data_start, 3'h6);
        transceive_cmd = 1'b0;
        pulse(cmd_idle);
        rc(6'h08, 8'hFF, 8'h00, "phase idle");
        end_of_test;
    end
endmodule
